// ===== src/radio_learn_pkg.sv
package radio_learn_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 32'h017D_7840;
    localparam int unsigned MS_PER_S   = 32'h0000_03E8;
    localparam int unsigned T_PRE_S    = 32'h0000_0003;
    localparam int unsigned T_GAP_S    = 32'h0000_0001;
    localparam int unsigned T_LEARN_S  = 32'h0000_0005;
    localparam int unsigned T_SELECT_S = 32'h0000_0003;
    localparam int unsigned T_HOLD_S   = 32'h0000_0005;
    localparam int unsigned T_BLINK_MS = 32'h0000_0064;
    localparam int unsigned T_RELAY_MS = 32'h0000_01F4;
    localparam int unsigned MS_W       = 32'h0000_000D;

    localparam logic [12:0] MS_PRE    = 13'(T_PRE_S * MS_PER_S);
    localparam logic [12:0] MS_GAP    = 13'(T_GAP_S * MS_PER_S);
    localparam logic [12:0] MS_LEARN  = 13'(T_LEARN_S * MS_PER_S);
    localparam logic [12:0] MS_SELECT = 13'(T_SELECT_S * MS_PER_S);
    localparam logic [12:0] MS_HOLD   = 13'(T_HOLD_S * MS_PER_S);
    localparam logic [12:0] MS_BLINK  = 13'(T_BLINK_MS);
    localparam logic [12:0] MS_RELAY  = 13'(T_RELAY_MS);

    // ---------------------------------------------------------------
    // Memory
    // ---------------------------------------------------------------
    localparam int unsigned CODE_W     = 32'h0000_0018;
    localparam int unsigned DEPTH_FIX  = 32'h0000_0010;
    localparam int unsigned DEPTH_ROLL = 32'h0000_0200;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_BOOT   = 4'b0000,
        ST_IDLE   = 4'b0001,
        ST_MATCH  = 4'b0010,
        ST_SELECT = 4'b0011,
        ST_PRE    = 4'b0100,
        ST_GAP    = 4'b0101,
        ST_LEARN  = 4'b0110,
        ST_HOLD   = 4'b0111,
        ST_BLINK  = 4'b1000,
        ST_ERASE  = 4'b1001
    } state_t;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_CH1    = 2'b01,
        MODE_CH2    = 2'b10
    } mode_t;

    typedef struct packed {
        logic red;
        logic green;
    } lamp_t;

    typedef struct packed {
        logic ch1;
        logic ch2;
    } relay_t;

    typedef struct packed {
        logic              chan2;
        logic [CODE_W-1:0] code;
    } entry_t;

endpackage : radio_learn_pkg

// ===== src/radio_receiver_learn_logic.sv
`timescale 1ns/1ps
`default_nettype none
module radio_receiver_learn_logic
    import radio_learn_pkg::*;
#(
    parameter bit          DUAL_CH  = 1'b1,
    parameter bit          ROLLING  = 1'b0,
    parameter int unsigned TICK_CYC = CLK_HZ / MS_PER_S
) (
    // Clock, reset, enable
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    input  wire logic                    clk_en,
    // Push-button
    input  wire logic                    learn_button,
    // Radio decoder
    input  wire logic                    code_valid,
    input  wire logic [radio_learn_pkg::CODE_W-1:0] code_data,
    // Indicators and relays
    output var  radio_learn_pkg::lamp_t  lamp,
    output var  radio_learn_pkg::relay_t relay
);
    import radio_learn_pkg::*;

    localparam int unsigned DEPTH = ROLLING ? DEPTH_ROLL : DEPTH_FIX;
    localparam int unsigned AW    = $clog2(DEPTH);
    localparam int unsigned TW    = $clog2(TICK_CYC) + 1;

    function automatic logic expired(input logic tk, input logic [12:0] cnt,
                                     input logic [12:0] lim);
        expired = tk && (cnt >= lim - 13'h0001);
    endfunction : expired

    state_t            state_q, state_d;
    mode_t             mode_q;
    logic              btn_q, press, restart, tick_q, phase_q, hit;
    logic [TW-1:0]     tick_cnt_q;
    logic [12:0]       ms_q, relay_ms_q;
    logic [AW-1:0]     idx_q;
    logic [AW:0]       fill_q;
    logic [CODE_W-1:0] code_q;
    entry_t            mem [DEPTH];
    logic [DEPTH-1:0]  valid_q;

    assign press = learn_button && !btn_q;
    assign hit   = valid_q[idx_q] && (mem[idx_q].code == code_q);

    // ---------------------------------------------------------------
    // Millisecond tick and state timer
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (clk_en) begin
            tick_q <= (tick_cnt_q == TW'(TICK_CYC - 1));
            if (tick_cnt_q == TW'(TICK_CYC - 1)) begin
                tick_cnt_q <= '0;
            end else begin
                tick_cnt_q <= tick_cnt_q + TW'(1);
            end
        end
    end

    assign restart = (state_d != state_q) || (state_q == ST_LEARN && code_valid)
                   || (state_q == ST_SELECT && press)
                   || (state_q == ST_BLINK && expired(tick_q, ms_q, MS_BLINK));

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ms_q <= '0;
        end else if (clk_en) begin
            if (restart) begin
                ms_q <= '0;
            end else if (tick_q) begin
                ms_q <= ms_q + 13'h0001;
            end
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_BOOT:   state_d = learn_button ? ST_HOLD : ST_IDLE;
            ST_IDLE: begin
                if (press) begin
                    state_d = ST_SELECT;
                end else if (code_valid) begin
                    state_d = ST_MATCH;
                end
            end
            ST_MATCH: begin
                if (hit || idx_q == AW'(DEPTH - 1)) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SELECT: begin
                if (!press && expired(tick_q, ms_q, MS_SELECT)) begin
                    state_d = (mode_q == MODE_NORMAL) ? ST_IDLE : ST_PRE;
                end
            end
            ST_PRE:    if (expired(tick_q, ms_q, MS_PRE)) state_d = ST_GAP;
            ST_GAP:    if (expired(tick_q, ms_q, MS_GAP)) state_d = ST_LEARN;
            ST_LEARN: begin
                if (!code_valid && expired(tick_q, ms_q, MS_LEARN)) begin
                    state_d = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (!learn_button) begin
                    state_d = ST_IDLE;
                end else if (expired(tick_q, ms_q, MS_HOLD)) begin
                    state_d = ST_BLINK;
                end
            end
            ST_BLINK:  if (!learn_button) state_d = ST_ERASE;
            ST_ERASE:  if (idx_q == AW'(DEPTH - 1)) state_d = ST_IDLE;
            default:   state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_BOOT;
            btn_q   <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            btn_q   <= learn_button;
        end
    end

    // Mode selection; presses in PRE/GAP/LEARN fall through unused
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_NORMAL;
        end else if (clk_en) begin
            if (state_q == ST_IDLE && press) begin
                mode_q <= MODE_CH1;
            end else if (state_q == ST_SELECT && press) begin
                unique case (mode_q)
                    MODE_NORMAL: mode_q <= MODE_CH1;
                    MODE_CH1:    mode_q <= DUAL_CH ? MODE_CH2 : MODE_NORMAL;
                    MODE_CH2:    mode_q <= MODE_NORMAL;
                    default:     mode_q <= MODE_NORMAL;
                endcase
            end else if (state_d == ST_IDLE) begin
                mode_q <= MODE_NORMAL;
            end
        end
    end

    // Scan / erase index and latched code
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            idx_q  <= '0;
            code_q <= '0;
        end else if (clk_en) begin
            if (state_q == ST_MATCH || state_q == ST_ERASE) begin
                idx_q <= idx_q + AW'(1);
            end else begin
                idx_q <= '0;
            end
            if (state_q == ST_IDLE && code_valid) begin
                code_q <= code_data;
            end
        end
    end

    // ---------------------------------------------------------------
    // Code memory, kept without reset
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            if (state_q == ST_LEARN && code_valid && fill_q < (AW+1)'(DEPTH)) begin
                mem[fill_q[AW-1:0]]     <= '{chan2: (mode_q == MODE_CH2),
                                             code: code_data};
                valid_q[fill_q[AW-1:0]] <= 1'b1;
                fill_q                  <= fill_q + (AW+1)'(1);
            end else if (state_q == ST_ERASE) begin
                valid_q[idx_q] <= 1'b0;
                fill_q         <= '0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Lamp and relays
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 1'b0;
            lamp    <= '0;
        end else if (clk_en) begin
            if (state_q == ST_BLINK && expired(tick_q, ms_q, MS_BLINK)) begin
                phase_q <= !phase_q;
            end
            lamp <= '0;
            unique case (state_q)
                ST_HOLD:          lamp.red <= 1'b1;
                ST_BLINK:         lamp     <= '{red: !phase_q, green: phase_q};
                ST_PRE, ST_LEARN: lamp     <= '{red: mode_q == MODE_CH1,
                                                green: mode_q == MODE_CH2};
                default:          lamp     <= '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            relay      <= '0;
            relay_ms_q <= '0;
        end else if (clk_en) begin
            if (state_q == ST_MATCH && hit) begin
                relay      <= '{ch1: !mem[idx_q].chan2, ch2: mem[idx_q].chan2};
                relay_ms_q <= '0;
            end else if (expired(tick_q, relay_ms_q, MS_RELAY)) begin
                relay <= '0;
            end else if (tick_q && relay != '0) begin
                relay_ms_q <= relay_ms_q + 13'h0001;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_PRE_LAMP: assert property (
        clk_en && state_q == ST_PRE && mode_q == MODE_CH1 |=> clk_en |-> lamp.red && !lamp.green)
        else $error("red lamp not lit in channel-one prelude");
    AST_GAP_DARK: assert property (
        clk_en && state_q == ST_GAP |=> lamp == '0)
        else $error("lamp lit during gap");
    AST_STORE: assert property (
        clk_en && state_q == ST_LEARN && code_valid && fill_q < (AW+1)'(DEPTH)
        |=> fill_q == $past(fill_q) + (AW+1)'(1))
        else $error("learned code not stored");
    AST_REOPEN: assert property (
        clk_en && state_q == ST_LEARN && code_valid |=> state_q == ST_LEARN && ms_q == '0)
        else $error("learning window not restarted");
    AST_LEARN_EXIT: assert property (
        clk_en && state_q == ST_LEARN && !code_valid && expired(tick_q, ms_q, MS_LEARN)
        |=> state_q == ST_IDLE)
        else $error("learning did not end after window");
    AST_ADVANCE: assert property (
        clk_en && state_q == ST_SELECT && press && mode_q == MODE_CH1 && DUAL_CH
        |=> mode_q == MODE_CH2)
        else $error("mode did not advance");
    AST_SINGLE: assert property (!DUAL_CH |-> mode_q != MODE_CH2)
        else $error("mode two on single-channel build");
    AST_LOCK: assert property (
        clk_en && (state_q inside {ST_PRE, ST_GAP, ST_LEARN}) && state_d == state_q
        |=> $stable(mode_q))
        else $error("mode changed while locked");
    AST_BOOT_ERASE: assert property (
        clk_en && state_q == ST_BOOT && learn_button |=> state_q == ST_HOLD ##1 clk_en |-> lamp.red)
        else $error("held button at power-up did not start erase hold");
    AST_ERASE_DONE: assert property (
        clk_en && state_q == ST_ERASE && state_d == ST_IDLE |=> fill_q == '0 && valid_q == '0)
        else $error("memory not cleared by erase");
    AST_RELAY: assert property (
        clk_en && state_q == ST_MATCH && hit |=> relay != '0)
        else $error("matched code did not drive relay");

    COV_LEARN_CH1: cover property (state_q == ST_LEARN && mode_q == MODE_CH1 && code_valid);
    COV_LEARN_CH2: cover property (state_q == ST_LEARN && mode_q == MODE_CH2 && code_valid);
    COV_ERASE:     cover property (state_q == ST_ERASE ##1 state_q == ST_IDLE);
    COV_RELAY:     cover property (state_q == ST_MATCH && hit);

endmodule : radio_receiver_learn_logic
`default_nettype wire

// ===== test/tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module tx_model
    import radio_learn_pkg::*;
(
    // Clock
    input  wire logic                                ref_clk,
    // Decoder side
    output var  logic                                code_valid,
    output var  logic [radio_learn_pkg::CODE_W-1:0] code_data
);
    logic              pend;
    logic [CODE_W-1:0] word;

    initial begin
        code_valid = 1'b0;
        code_data  = '0;
        pend       = 1'b0;
        word       = '0;
    end

    // ---------------------------------------------------------------
    // Decoder output, data toggles while no word is offered
    // ---------------------------------------------------------------
    always @(negedge ref_clk) begin
        if (pend) begin
            code_valid <= 1'b1;
            code_data  <= word;
            pend = 1'b0;
        end else begin
            code_valid <= 1'b0;
            code_data  <= ~code_data;
        end
    end

    // One button press of a handset, one pulse; presses may follow back to back
    task automatic send(input logic [CODE_W-1:0] code);
        @(posedge ref_clk);
        word = code;
        pend = 1'b1;
        @(posedge ref_clk);
    endtask : send
endmodule : tx_model
`default_nettype wire

// ===== test/radio_receiver_learn_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module radio_receiver_learn_logic_test;
    import radio_learn_pkg::*;
    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    localparam int unsigned       TICK   = 2;
    localparam logic [CODE_W-1:0] CODE_A = 24'h5A_C3E1;
    localparam logic [CODE_W-1:0] CODE_B = 24'h0F_1E2D;
    localparam logic [CODE_W-1:0] CODE_C = 24'h33_CC55;
    localparam logic [CODE_W-1:0] CODE_D = 24'h77_0011;
    logic              ref_clk;
    logic              rstn;
    logic              clk_en;
    logic              learn_button;
    logic              code_valid;
    logic [CODE_W-1:0] code_data;
    lamp_t             lamp;
    relay_t            relay;
    int                failures;
    int                total_checks;

    radio_receiver_learn_logic #(.DUAL_CH(1'b1), .ROLLING(1'b0), .TICK_CYC(TICK))
    radio_receiver_learn_logic_i (
        .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .learn_button(learn_button),
        .code_valid(code_valid), .code_data(code_data), .lamp(lamp), .relay(relay)
    );
    tx_model tx_model_i (.ref_clk(ref_clk), .code_valid(code_valid), .code_data(code_data));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask : check

    task automatic wait_ms(input int unsigned n);
        repeat (n * TICK) @(negedge ref_clk);
    endtask : wait_ms

    task automatic press();
        @(negedge ref_clk);
        learn_button = 1'b1;
        repeat (4) @(negedge ref_clk);
        learn_button = 1'b0;
        @(negedge ref_clk);
    endtask : press

    task automatic lamp_at(input int unsigned ms, input lamp_t exp, input string msg);
        wait_ms(ms);
        check(lamp === exp, msg);
    endtask : lamp_at

    task automatic match(input logic [CODE_W-1:0] code, input relay_t exp, input string msg);
        relay_t seen;
        seen = '0;
        tx_model_i.send(code);
        repeat (40) begin
            @(negedge ref_clk);
            seen = seen | relay;
        end
        check(seen === exp, msg);
        wait_ms(520);
    endtask : match

    task automatic summarize();
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic s_erase();
        int reds;
        int greens;
        int other;
        reds   = 0;
        greens = 0;
        other  = 0;
        lamp_at(2500, 2'b10, "red lamp while button held at power-up");
        wait_ms(3000);
        repeat (200 * TICK) begin
            @(negedge ref_clk);
            if (lamp === 2'b10) reds++;
            else if (lamp === 2'b01) greens++;
            else other++;
        end
        check(reds > 0 && greens > 0 && other == 0, "blink not alternating");
        learn_button = 1'b0;
        repeat (100) @(negedge ref_clk);
        check(lamp === 2'b00, "lamp not off after erase");
        match(CODE_A, 2'b00, "erased memory still matches");
    endtask : s_erase

    task automatic s_learn1();
        press();
        lamp_at(1500, 2'b00, "lamp lit while selecting");
        lamp_at(3000, 2'b10, "red first window missing");
        press();
        lamp_at(2000, 2'b00, "lamp lit during gap");
        lamp_at(1500, 2'b10, "red learning window missing");
        tx_model_i.send(CODE_A);
        lamp_at(3000, 2'b10, "learning window closed early");
        tx_model_i.send(CODE_B);
        lamp_at(4500, 2'b10, "second code did not reopen window");
        lamp_at(1000, 2'b00, "programming not left after 5 s");
        match(CODE_A, 2'b10, "first code not on channel one");
        match(CODE_B, 2'b10, "second code not on channel one");
        match(CODE_D, 2'b00, "unstored code drove a relay");
    endtask : s_learn1

    task automatic s_modes();
        press();
        wait_ms(500);
        press();
        wait_ms(500);
        press();
        lamp_at(4500, 2'b00, "mode did not wrap to normal");
        press();
        wait_ms(1000);
        press();
        lamp_at(4500, 2'b01, "green first window missing");
        lamp_at(2000, 2'b00, "lamp lit during green gap");
        lamp_at(1500, 2'b01, "green learning window missing");
        tx_model_i.send(CODE_C);
        lamp_at(5500, 2'b00, "channel two learning not left");
        match(CODE_C, 2'b01, "code not on channel two");
        match(CODE_A, 2'b10, "channel one code lost");
    endtask : s_modes

    task automatic s_keep();
        @(negedge ref_clk);
        rstn = 1'b0;
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        match(CODE_A, 2'b10, "code lost over reset");
    endtask : s_keep

    // ---------------------------------------------------------------
    // Clock, sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        rstn         = 1'b0;
        clk_en       = 1'b1;
        learn_button = 1'b1;
        failures     = 0;
        total_checks = 0;
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        s_erase();
        s_learn1();
        s_modes();
        s_keep();
        summarize();
    end

    initial begin
        repeat (99000) @(posedge ref_clk);
        failures++;
        summarize();
    end
endmodule : radio_receiver_learn_logic_test
`default_nettype wire
